// [core/gjc_pkg.sv]
`default_nettype none
package gjc_pkg;
  // ************************************************************
  // Register map (word offsets as byte addresses)
  // ************************************************************
  localparam logic [7:0] GJC_CTRL_OFS = 8'h00;
  localparam logic [7:0] GJC_TX_CNT_OFS = 8'h04;
  localparam logic [7:0] GJC_TX_PHASE_OFS = 8'h08;
  localparam logic [7:0] GJC_TX_OCT_LO_OFS = 8'h0C;
  localparam logic [7:0] GJC_TX_OCT_HI_OFS = 8'h10;
  localparam logic [7:0] GJC_RX_OCT_LO_OFS = 8'h14;
  localparam logic [7:0] GJC_RX_OCT_HI_OFS = 8'h18;
  localparam logic [7:0] GJC_RX_CNT_OFS = 8'h1C;
  localparam logic [7:0] GJC_RX_PHASE_OFS = 8'h20;
  localparam logic [7:0] GJC_STATUS_OFS = 8'h24;
  localparam logic [7:0] GJC_PSIZE_OFS = 8'h28;
  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int GJC_CTRL_KORDER_BIT = 0;
  localparam int GJC_CTRL_TX_GO_BIT = 1;
  localparam int GJC_CTRL_RX_GO_BIT = 2;
  localparam int GJC_CTRL_FSTART_BIT = 3;
  localparam int GJC_ST_SYNC_BIT = 0;
  localparam int GJC_ST_CNT_ERR_BIT = 1;
  localparam int GJC_ST_PH_ERR_BIT = 2;
  localparam int GJC_ST_CLAMP_BIT = 3;
  localparam logic [9:0] GJC_PSIZE_RST = 10'h3B8;
  localparam logic [9:0] GJC_ONE = 10'h001;
  localparam logic [9:0] GJC_TWO = 10'h002;
  // Inversion masks, C1 is bit 9 and C10 is bit 0
  localparam logic [9:0] GJC_MASK_P1 = 10'h2AA;
  localparam logic [9:0] GJC_MASK_M1 = 10'h259;
  localparam logic [9:0] GJC_MASK_P2 = 10'h165;
  localparam logic [9:0] GJC_MASK_M2 = 10'h196;
  // Generator taps below the top degree
  localparam logic [5:0] GJC_G6 = 6'h0D;
  localparam logic [4:0] GJC_G5 = 5'h03;
  localparam logic [8:0] GJC_G9 = 9'h00D;
  typedef enum logic [1:0] {
    GJC_SINK_HUNT = 2'b00,
    GJC_SINK_ARM = 2'b01,
    GJC_SINK_SYNC = 2'b11
  } gjc_sink_t;
  typedef struct packed {
    logic [7:0] oct1;
    logic [7:0] oct2;
    logic [7:0] oct3;
    logic [7:0] oct4;
    logic [7:0] oct5;
    logic [7:0] oct6;
  } gjc_octets_t;
endpackage
`default_nettype wire

// [core/gjc_codec.sv]
`default_nettype none
module gjc_codec (
  input wire logic pclk, // Server frame clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready, always high
  output logic pslverr, // APB error on unmapped address
  input wire logic pos_valid, // Payload position strobe
  output logic map_read_en, // Mapper buffer read strobe
  output logic demap_write_en, // De-mapper buffer write strobe
  output gjc_pkg::gjc_octets_t tx_octets, // Mapper octets to send
  output logic sink_synced // Sink count trusted
);
  import gjc_pkg::*;

  // ************************************************************
  // CRC helpers
  // ************************************************************
  function automatic logic [8:0] crc_div(input logic [26:0] msg, input int len,
                                         input int deg, input logic [8:0] taps);
    logic [8:0] r;
    logic fb;
    r = '0;
    for (int i = 26; i >= 0; i--) begin
      if (i < len) begin
        fb = msg[i] ^ r[deg-1];
        // Bits above the degree never feed back and are masked below
        r = {r[7:0], 1'b0};
        if (fb) begin
          r = r ^ taps;
        end
      end
    end
    for (int j = 8; j >= 0; j--) begin
      if (j >= deg) begin
        r[j] = 1'b0;
      end
    end
    return r;
  endfunction

  // ************************************************************
  // Registers
  // ************************************************************
  logic [3:0] ctrl_r;
  logic [9:0] tx_cnt_r;
  logic [17:0] tx_phase_r;
  logic [9:0] psize_r;
  logic [23:0] rx_lo_r;
  logic [23:0] rx_hi_r;
  logic [9:0] rx_cnt_r;
  logic [17:0] rx_phase_r;
  logic [3:0] status_r;
  logic [9:0] prev_cnt_r;
  logic [9:0] map_cnt_r;
  logic [17:0] psum_r;
  logic [9:0] map_acc_r;
  logic [9:0] dem_acc_r;
  gjc_sink_t sink_r;
  logic [9:0] pred_r;
  logic [9:0] hunt_mask_r;
  logic [9:0] hunt_step_r;
  logic hunt_up_r;
  logic acc_ok;
  logic wr_en;
  logic rd_en;
  logic tx_go;
  logic rx_go;
  logic fstart;

  assign acc_ok = psel & penable;
  assign wr_en = acc_ok & pwrite;
  assign rd_en = acc_ok & ~pwrite;
  assign pready = 1'b1;
  assign tx_go = wr_en && paddr == GJC_CTRL_OFS && pwdata[GJC_CTRL_TX_GO_BIT];
  assign rx_go = wr_en && paddr == GJC_CTRL_OFS && pwdata[GJC_CTRL_RX_GO_BIT];
  assign fstart = wr_en && paddr == GJC_CTRL_OFS && pwdata[GJC_CTRL_FSTART_BIT];

  // Mode and configuration writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= '0;
      tx_cnt_r <= '0;
      tx_phase_r <= '0;
      psize_r <= GJC_PSIZE_RST;
      rx_lo_r <= '0;
      rx_hi_r <= '0;
    end else if (wr_en) begin
      case (paddr)
        GJC_CTRL_OFS: ctrl_r <= {3'b000, pwdata[GJC_CTRL_KORDER_BIT]};
        GJC_TX_CNT_OFS: tx_cnt_r <= pwdata[9:0];
        GJC_TX_PHASE_OFS: tx_phase_r <= pwdata[17:0];
        GJC_PSIZE_OFS: psize_r <= pwdata[9:0];
        GJC_RX_OCT_LO_OFS: rx_lo_r <= pwdata[23:0];
        GJC_RX_OCT_HI_OFS: rx_hi_r <= pwdata[23:0];
        default: ctrl_r <= ctrl_r;
      endcase
    end
  end

  // ************************************************************
  // Mapper count and phase
  // ************************************************************
  logic korder;
  logic [9:0] step_cnt;
  logic [10:0] step_wide;
  logic [17:0] psum_add;
  logic [17:0] step_ph;
  logic bump;
  logic [9:0] cnt_sel;
  logic [9:0] cnt_lim;
  logic clamp;
  logic [17:0] ph_out;

  assign korder = ctrl_r[GJC_CTRL_KORDER_BIT];
  // Phase step is the payload size in fine units, from software
  assign step_ph = {8'h00, psize_r};
  assign psum_add = psum_r + tx_phase_r;
  assign bump = psum_add >= step_ph;
  assign step_wide = {1'b0, tx_cnt_r} + {10'h000, bump};
  assign step_cnt = step_wide[9:0];
  // count clamp, on the wide sum so a full count plus a bump cannot wrap
  assign clamp = step_wide > {1'b0, psize_r};
  assign cnt_lim = clamp ? psize_r : step_cnt;
  assign cnt_sel = cnt_lim;
  assign ph_out = bump ? psum_add - step_ph : psum_add;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_cnt_r <= '0;
      map_cnt_r <= '0;
      psum_r <= '0;
    end else if (tx_go) begin
      prev_cnt_r <= cnt_sel;
      map_cnt_r <= cnt_sel;
      psum_r <= ph_out;
    end
  end

  logic [9:0] enc_cnt;
  logic inc_f;
  logic dec_f;
  always_comb begin
    enc_cnt = cnt_sel;
    inc_f = 1'b0;
    dec_f = 1'b0;
    if (cnt_sel == prev_cnt_r + GJC_TWO) begin
      enc_cnt = cnt_sel ^ GJC_MASK_P2;
      inc_f = 1'b1;
    end else if (cnt_sel == prev_cnt_r + GJC_ONE) begin
      enc_cnt = cnt_sel ^ GJC_MASK_P1;
      inc_f = 1'b1;
    end else if (cnt_sel == prev_cnt_r - GJC_ONE) begin
      enc_cnt = cnt_sel ^ GJC_MASK_M1;
      dec_f = 1'b1;
    end else if (cnt_sel == prev_cnt_r - GJC_TWO) begin
      enc_cnt = cnt_sel ^ GJC_MASK_M2;
      dec_f = 1'b1;
    end else if (cnt_sel != prev_cnt_r) begin
      inc_f = 1'b1;
      dec_f = 1'b1;
    end
  end

  logic [11:0] cnt_bits;
  logic [5:0] crc6_tx;
  logic [9:0] d10;
  logic [4:0] crc5_tx;
  logic [8:0] crc9_tx;
  logic [8:0] crc6_full;
  logic [8:0] crc5_full;
  assign cnt_bits = {enc_cnt, inc_f, dec_f};
  // The divider already shifts in the degree's zeros, so only the message goes in
  assign crc6_full = crc_div({15'h0000, cnt_bits}, 12, 6, {3'b000, GJC_G6});
  assign crc6_tx = crc6_full[5:0];
  assign d10 = ph_out[9:0];
  assign crc5_full = crc_div({17'h00000, d10}, 10, 5, {4'h0, GJC_G5});
  assign crc5_tx = crc5_full[4:0];
  assign crc9_tx = crc_div({9'h000, ph_out}, 18, 9, GJC_G9);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_octets <= '0;
    end else if (tx_go) begin
      tx_octets.oct1 <= korder ? {2'b00, cnt_bits[11:6]} : {ph_out[10:9], cnt_bits[11:6]};
      tx_octets.oct2 <= korder ? {2'b00, cnt_bits[5:0]} : {ph_out[1:0], cnt_bits[5:0]};
      tx_octets.oct3 <= korder ? {2'b00, crc6_tx} : {crc9_tx[1:0], crc6_tx};
      // Cn phase placement
      // Octet bit 1 is the MSB, so bits 2-8 are the low seven
      tx_octets.oct4 <= korder ? {3'b000, d10[9:5]} : {1'b0, ph_out[17:11]};
      tx_octets.oct5 <= korder ? {3'b000, d10[4:0]} : {1'b0, ph_out[8:2]};
      tx_octets.oct6 <= korder ? {3'b000, crc5_tx} : {1'b0, crc9_tx[8:2]};
    end
  end

  // ************************************************************
  // De-mapper sink
  // ************************************************************
  logic [7:0] r1, r2, r3, r4, r5, r6;
  logic [9:0] rx_c;
  logic rx_i;
  logic rx_d;
  logic [8:0] chk6;
  logic [8:0] chk5;
  logic [8:0] chk9;
  logic cnt_ok;
  logic ph_ok;
  logic [17:0] rx_ph;
  assign {r1, r2, r3} = rx_lo_r;
  assign {r4, r5, r6} = rx_hi_r;
  assign {rx_c, rx_i, rx_d} = {r1[5:0], r2[5:0]};
  assign chk6 = crc_div({9'h000, r1[5:0], r2[5:0], r3[5:0]}, 18, 6, {3'b000, GJC_G6});
  assign cnt_ok = chk6 == 9'h000;
  assign chk5 = crc_div({12'h000, r4[4:0], r5[4:0], r6[4:0]}, 15, 5, {4'h0, GJC_G5});
  assign chk9 = crc_div({r4[6:0], r1[7:6], r5[6:0], r2[7:6], r6[6:0], r3[7:6]},
                        27, 9, GJC_G9);
  assign ph_ok = korder ? chk5 == 9'h000 : chk9 == 9'h000;
  assign rx_ph = korder ? {8'h00, r4[4:0], r5[4:0]} :
                 {r4[6:0], r1[7:6], r5[6:0], r2[7:6]};

  // hunt mask from the increment flag and LSB
  logic [9:0] h_mask;
  logic [9:0] h_step;
  always_comb begin
    h_mask = GJC_MASK_M1;
    h_step = GJC_ONE;
    if (rx_i) begin
      h_mask = (rx_c[0] ^ GJC_MASK_P1[0]) ? GJC_MASK_P2 : GJC_MASK_P1;
      h_step = (rx_c[0] ^ GJC_MASK_P1[0]) ? GJC_TWO : GJC_ONE;
    end else begin
      h_mask = (rx_c[0] ^ GJC_MASK_M1[0]) ? GJC_MASK_M2 : GJC_MASK_M1;
      h_step = (rx_c[0] ^ GJC_MASK_M1[0]) ? GJC_TWO : GJC_ONE;
    end
  end

  logic [9:0] dec_cnt;
  logic [9:0] dec_nxt;
  assign dec_cnt = rx_c ^ hunt_mask_r;
  assign dec_nxt = hunt_up_r ? dec_cnt + hunt_step_r : dec_cnt - hunt_step_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sink_r <= GJC_SINK_HUNT;
      pred_r <= '0;
      hunt_mask_r <= '0;
      hunt_step_r <= '0;
      hunt_up_r <= 1'b0;
      rx_cnt_r <= '0;
    end else if (rx_go && cnt_ok) begin
      case (sink_r)
        GJC_SINK_HUNT: begin
          if (rx_i != rx_d) begin
            hunt_mask_r <= h_mask;
            hunt_step_r <= h_step;
            hunt_up_r <= rx_i;
            sink_r <= GJC_SINK_ARM;
          end else if (!rx_i) begin
            pred_r <= rx_c;
          end
        end
        GJC_SINK_ARM: begin
          rx_cnt_r <= dec_nxt;
          pred_r <= dec_nxt;
          sink_r <= GJC_SINK_SYNC;
        end
        GJC_SINK_SYNC: begin
          if (rx_i & rx_d) begin
            rx_cnt_r <= rx_c;
          end else if (rx_i | rx_d) begin
            rx_cnt_r <= rx_c ^ h_mask;
          end
        end
        default: sink_r <= GJC_SINK_HUNT;
      endcase
    end
  end
  assign sink_synced = sink_r == GJC_SINK_SYNC;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_phase_r <= '0;
    end else if (rx_go && ph_ok) begin
      rx_phase_r <= rx_ph;
    end
  end

  // sticky errors, set wins over read-clear
  logic st_rd;
  assign st_rd = rd_en && paddr == GJC_STATUS_OFS;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= '0;
    end else begin
      status_r[GJC_ST_SYNC_BIT] <= sink_synced;
      status_r[GJC_ST_CNT_ERR_BIT] <= (rx_go & ~cnt_ok) |
                                      (status_r[GJC_ST_CNT_ERR_BIT] & ~st_rd);
      status_r[GJC_ST_PH_ERR_BIT] <= (rx_go & ~ph_ok) |
                                     (status_r[GJC_ST_PH_ERR_BIT] & ~st_rd);
      status_r[GJC_ST_CLAMP_BIT] <= (tx_go & clamp) |
                                    (status_r[GJC_ST_CLAMP_BIT] & ~st_rd);
    end
  end

  // ************************************************************
  // Sigma-delta accumulators
  // ************************************************************
  logic [10:0] map_sum;
  logic [10:0] dem_sum;
  assign map_sum = {1'b0, map_acc_r} + {1'b0, map_cnt_r};
  assign dem_sum = {1'b0, dem_acc_r} + {1'b0, rx_cnt_r};

  // identical data/stuff decisions at both ends, with demap_write_en also gated by sink_synced
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      map_acc_r <= '0;
      dem_acc_r <= '0;
      map_read_en <= 1'b0;
      demap_write_en <= 1'b0;
    end else if (fstart) begin
      map_acc_r <= '0;
      dem_acc_r <= '0;
      map_read_en <= 1'b0;
      demap_write_en <= 1'b0;
    end else begin
      map_read_en <= pos_valid && map_sum >= {1'b0, psize_r};
      demap_write_en <= pos_valid && sink_synced && dem_sum >= {1'b0, psize_r};
      if (pos_valid) begin
        map_acc_r <= map_sum >= {1'b0, psize_r} ? 10'(map_sum - {1'b0, psize_r}) : map_sum[9:0];
        dem_acc_r <= dem_sum >= {1'b0, psize_r} ? 10'(dem_sum - {1'b0, psize_r}) : dem_sum[9:0];
      end
    end
  end

  // ************************************************************
  // APB read path
  // ************************************************************
  always_comb begin
    prdata = '0;
    pslverr = 1'b0;
    case (paddr)
      GJC_CTRL_OFS: prdata = {28'h0000000, ctrl_r};
      GJC_TX_CNT_OFS: prdata = {22'h000000, tx_cnt_r};
      GJC_TX_PHASE_OFS: prdata = {14'h0000, tx_phase_r};
      GJC_TX_OCT_LO_OFS: prdata = {8'h00, tx_octets.oct1, tx_octets.oct2, tx_octets.oct3};
      GJC_TX_OCT_HI_OFS: prdata = {8'h00, tx_octets.oct4, tx_octets.oct5, tx_octets.oct6};
      GJC_RX_OCT_LO_OFS: prdata = {8'h00, rx_lo_r};
      GJC_RX_OCT_HI_OFS: prdata = {8'h00, rx_hi_r};
      GJC_RX_CNT_OFS: prdata = {22'h000000, rx_cnt_r};
      GJC_RX_PHASE_OFS: prdata = {14'h0000, rx_phase_r};
      GJC_STATUS_OFS: prdata = {28'h0000000, status_r};
      GJC_PSIZE_OFS: prdata = {22'h000000, psize_r};
      default: pslverr = acc_ok;
    endcase
  end

  // ************************************************************
  // Checks
  // ************************************************************
  property p_clamp;
    @(posedge pclk) disable iff (!presetn) tx_go |=> map_cnt_r <= psize_r;
  endproperty
  a_clamp: assert property (p_clamp) else $error("count above payload");
  property p_fstart;
    @(posedge pclk) disable iff (!presetn) fstart |=> map_acc_r == 10'h000 && !map_read_en;
  endproperty
  a_fstart: assert property (p_fstart) else $error("accumulator not cleared");
  property p_acc;
    @(posedge pclk) disable iff (!presetn) map_acc_r < psize_r || $past(fstart) || $past(tx_go);
  endproperty
  a_acc: assert property (p_acc) else $error("accumulator overrange");
  property p_cnt_err;
    @(posedge pclk) disable iff (!presetn) rx_go && !cnt_ok |=> status_r[GJC_ST_CNT_ERR_BIT];
  endproperty
  a_cnt_err: assert property (p_cnt_err) else $error("count error not flagged");
  property p_ph_keep;
    @(posedge pclk) disable iff (!presetn) rx_go && !ph_ok |=> $stable(rx_phase_r);
  endproperty
  a_ph_keep: assert property (p_ph_keep) else $error("bad phase taken");
  property p_crc6;
    @(posedge pclk) disable iff (!presetn)
      tx_go |=> crc_div({9'h000, tx_octets.oct1[5:0], tx_octets.oct2[5:0],
                         tx_octets.oct3[5:0]}, 18, 6, {3'b000, GJC_G6}) == 9'h000;
  endproperty
  a_crc6: assert property (p_crc6) else $error("sent crc6 inconsistent");
  property p_flags;
    @(posedge pclk) disable iff (!presetn)
      tx_go && cnt_sel == prev_cnt_r |=> !tx_octets.oct2[1] && !tx_octets.oct2[0];
  endproperty
  a_flags: assert property (p_flags) else $error("flags set on no change");
  property p_sync;
    @(posedge pclk) disable iff (!presetn)
      sink_r == GJC_SINK_ARM && rx_go && cnt_ok |=> sink_synced;
  endproperty
  a_sync: assert property (p_sync) else $error("sink failed to sync");
endmodule
`default_nettype wire

// [bench/gjc_peer_model.sv]
`default_nettype none
module gjc_peer_model (
  input wire logic [9:0] word, // Count bits as they go on the wire
  input wire logic increment_flag, // Increment indicator
  input wire logic decrement_flag, // Decrement indicator
  input wire logic [17:0] phase, // residual_phase_sum, D1 is the top bit
  input wire logic korder, // High for the ten-bit phase layout
  output gjc_pkg::gjc_octets_t octets // Octets a peer mapper would send
);
  timeunit 1ns;
  timeprecision 1ps;
  import gjc_pkg::*;

  // ************************************************************
  // Check word arithmetic
  // ************************************************************
  // Serial long division; the appended zeros are implied by the shift
  function automatic logic [8:0] crc_f(input logic [17:0] m, input int nb, input int deg,
                                       input logic [8:0] taps);
    logic [8:0] r;
    logic fb;
    r = 9'h000;
    for (int i = nb - 1; i >= 0; i--) begin
      fb = m[i] ^ r[deg - 1];
      r = (r << 1) & ((9'h001 << deg) - 9'h001);
      if (fb) begin
        r = r ^ taps;
      end
    end
    return r;
  endfunction

  logic [8:0] crc6;
  logic [8:0] crc5;
  logic [8:0] crc9;
  assign crc6 = crc_f({6'h00, word, increment_flag, decrement_flag}, 12, 6, 9'h00D);
  assign crc5 = crc_f({8'h00, phase[9:0]}, 10, 5, 9'h003);
  assign crc9 = crc_f(phase, 18, 9, 9'h00D);

  // ************************************************************
  // Octet placement
  // ************************************************************
  // placement per mode
  always_comb begin
    octets = 48'h000000000000;
    octets.oct1[5:0] = word[9:4];
    octets.oct2[5:0] = {word[3:0], increment_flag, decrement_flag};
    octets.oct3[5:0] = crc6[5:0];
    if (korder) begin
      octets.oct4[4:0] = phase[9:5];
      octets.oct5[4:0] = phase[4:0];
      octets.oct6[4:0] = crc5[4:0];
    end else begin
      octets.oct4[6:0] = phase[17:11];
      octets.oct1[7:6] = phase[10:9];
      octets.oct5[6:0] = phase[8:2];
      octets.oct2[7:6] = phase[1:0];
      octets.oct6[6:0] = crc9[8:2];
      octets.oct3[7:6] = crc9[1:0];
    end
  end
endmodule
`default_nettype wire

// [bench/tb_gjc_codec.sv]
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("[ERR] %0t got %h want %h", $time, got, exp); end end
module tb_gjc_codec;
  timeunit 1ns;
  timeprecision 1ps;
  import gjc_pkg::*;

  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pos_valid;
  logic map_read_en, demap_write_en, sink_synced, p_inc, p_dec, p_kord, rerr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [9:0] p_word;
  logic [17:0] p_phase;
  logic [10:0] rd_mask;
  gjc_octets_t tx_octets, peer_oct;
  int n_mismatch, tests_run, cyc, pidx, rd_n, wr_n;

  gjc_codec i_gjc_codec (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pos_valid(pos_valid), .map_read_en(map_read_en),
    .demap_write_en(demap_write_en), .tx_octets(tx_octets), .sink_synced(sink_synced));
  gjc_peer_model i_gjc_peer_model (.word(p_word), .increment_flag(p_inc),
    .decrement_flag(p_dec), .phase(p_phase), .korder(p_kord), .octets(peer_oct));

  // ************************************************************
  // Bus and frame tasks
  // ************************************************************
  // Request held until pready is seen high at an edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    `CHK(rdat, exp)
  endtask

  task set_peer(input logic [9:0] w, input logic i, d, input logic [17:0] ph, input logic k);
    p_word = w; p_inc = i; p_dec = d; p_phase = ph; p_kord = k;
    #1;
  endtask

  // Mapper frame: new count, then compare against a peer encoding
  task tx_frame(input logic [9:0] c, w, input logic i, d, input logic [17:0] ph, input logic k);
    apb(1'b1, GJC_TX_CNT_OFS, {22'h0, c});
    // Mode must be in place one write before the frame strobe
    apb(1'b1, GJC_CTRL_OFS, {31'h0, k});
    apb(1'b1, GJC_CTRL_OFS, {30'h0, 1'b1, k});
    set_peer(w, i, d, ph, k);
    repeat (2) @(posedge pclk);
    #1;
    `CHK(tx_octets, peer_oct)
  endtask

  // De-mapper frame from peer octets, optionally corrupted
  task rx_frame(input logic [9:0] w, input logic i, d, input logic [17:0] ph, input logic k,
                input logic [47:0] flip);
    logic [47:0] x;
    set_peer(w, i, d, ph, k);
    x = peer_oct ^ flip;
    apb(1'b1, GJC_RX_OCT_LO_OFS, {8'h00, x[47:24]});
    apb(1'b1, GJC_RX_OCT_HI_OFS, {8'h00, x[23:0]});
    apb(1'b1, GJC_CTRL_OFS, {31'h0, k});
    apb(1'b1, GJC_CTRL_OFS, {29'h0, 1'b1, 1'b0, k});
    repeat (2) @(posedge pclk);
  endtask

  // Positions are driven back to back so each read lands at mask index slot plus one
  task pos_run(input int n);
    #1;
    rd_mask = 11'h000; pidx = 0; rd_n = 0; wr_n = 0;
    repeat (n) begin
      @(posedge pclk);
      pos_valid <= 1'b1;
    end
    @(posedge pclk);
    pos_valid <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask

  task finish_test();
    $display("mismatches %0d, checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ************************************************************
  // Clock, monitor and sequence
  // ************************************************************
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // Strobe monitor; also cuts a hang short well past the expected run
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (pos_valid === 1'b1) pidx <= pidx + 1;
    if (map_read_en === 1'b1) begin
      rd_mask[pidx] <= 1'b1;
      rd_n <= rd_n + 1;
    end
    if (demap_write_en === 1'b1) wr_n <= wr_n + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      $display("[ERR] %0t timeout", $time);
      finish_test();
    end
  end

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; pos_valid = 1'b0; cyc = 0; n_mismatch = 0; tests_run = 0;
    set_peer(10'h000, 1'b0, 1'b0, 18'h00000, 1'b0);
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(GJC_PSIZE_OFS, {22'h0, GJC_PSIZE_RST});
    rd_chk(GJC_STATUS_OFS, 32'h0);
    apb(1'b0, 8'h2C, 32'h0);
    `CHK({rerr, rdat}, 33'h100000000)
    $display("registers done");
    apb(1'b1, GJC_TX_PHASE_OFS, 32'h0);
    tx_frame(10'h3FF, 10'h3B8, 1'b1, 1'b1, 18'h0, 1'b1);
    apb(1'b0, GJC_STATUS_OFS, 32'h0);
    `CHK(rdat[GJC_ST_CLAMP_BIT], 1'b1)
    apb(1'b1, GJC_CTRL_OFS, 32'h8);
    apb(1'b1, GJC_TX_PHASE_OFS, 32'h200);
    tx_frame(10'h100, 10'h100, 1'b1, 1'b1, 18'h200, 1'b0);
    tx_frame(10'h100, 10'h101 ^ 10'h2AA, 1'b1, 1'b0, 18'h048, 1'b0);
    apb(1'b1, GJC_TX_PHASE_OFS, 32'h0);
    tx_frame(10'h100, 10'h100 ^ 10'h259, 1'b0, 1'b1, 18'h048, 1'b0);
    tx_frame(10'h102, 10'h102 ^ 10'h165, 1'b1, 1'b0, 18'h048, 1'b0);
    tx_frame(10'h102, 10'h102, 1'b0, 1'b0, 18'h048, 1'b1);
    $display("mapper done");
    apb(1'b1, GJC_PSIZE_OFS, 32'hA);
    apb(1'b1, GJC_CTRL_OFS, 32'h9);
    apb(1'b1, GJC_TX_CNT_OFS, 32'h3);
    apb(1'b1, GJC_CTRL_OFS, 32'h3);
    apb(1'b1, GJC_CTRL_OFS, 32'h9);
    // Leftover phase sum exceeds the small step, so three becomes four
    pos_run(5);
    `CHK(rd_mask, 11'h028)
    apb(1'b1, GJC_CTRL_OFS, 32'h9);
    pos_run(10);
    `CHK(rd_mask, 11'h528)
    `CHK(rd_n, 4)
    `CHK(wr_n, 0)
    $display("sigma-delta done");
    rx_frame(10'h123, 1'b1, 1'b1, 18'h155, 1'b1, 48'h0);
    rd_chk(GJC_RX_PHASE_OFS, 32'h155);
    rd_chk(GJC_STATUS_OFS, 32'h0);
    rx_frame(10'h123, 1'b1, 1'b1, 18'h0AA, 1'b1, 48'h000000000001);
    rd_chk(GJC_RX_PHASE_OFS, 32'h155);
    rd_chk(GJC_STATUS_OFS, 32'h4);
    rx_frame(10'h200, 1'b1, 1'b1, 18'h155, 1'b1, 48'h000001000000);
    rd_chk(GJC_STATUS_OFS, 32'h2);
    rx_frame(10'h120 ^ 10'h2AA, 1'b1, 1'b0, 18'h155, 1'b1, 48'h0);
    `CHK(sink_synced, 1'b0)
    rx_frame(10'h121 ^ 10'h2AA, 1'b1, 1'b0, 18'h155, 1'b1, 48'h0);
    `CHK(sink_synced, 1'b1)
    rd_chk(GJC_RX_CNT_OFS, 32'h122);
    apb(1'b1, GJC_CTRL_OFS, 32'h9);
    pos_run(3);
    `CHK(wr_n, 3)
    rx_frame(10'h123, 1'b1, 1'b1, 18'h2A5A5, 1'b0, 48'h0);
    rd_chk(GJC_RX_PHASE_OFS, 32'h2A5A5);
    rd_chk(GJC_RX_CNT_OFS, 32'h123);
    $display("de-mapper done");
    finish_test();
  end
endmodule
`default_nettype wire
